// [core/irq_status_pkg.sv]
/*
 * Shared constants and types of the top-level interrupt status block:
 * register offsets, field positions, reset values, timing counts, the
 * register request carrier and the short-circuit watcher states.
 * Assumes a single 100 MHz clock and an 8-bit register port.
 */
`default_nettype none

package irq_status_pkg;

    // Register port widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [7:0] TOP_STATUS_ADDR = 8'h1a;
    localparam logic [7:0] LOWER_PAIR_ADDR = 8'h1c;
    localparam logic [7:0] UPPER_PAIR_ADDR = 8'h1d;
    localparam logic [7:0] TOP_MASK_ADDR = 8'h20;
    localparam logic [7:0] LIVE_STATUS_ADDR = 8'h21;
    localparam logic [7:0] CONFIG_ADDR = 8'h22;
    localparam logic [7:0] LOAD_LO_ADDR = 8'h23;
    localparam logic [7:0] LOAD_HI_ADDR = 8'h24;

    // Field positions of the top status and mask registers.
    localparam int BIT_LOAD_READY = 0;
    localparam int BIT_OVERVOLTAGE = 1;
    localparam int BIT_THERMAL_WARN = 2;
    localparam int BIT_THERMAL_SD = 3;
    localparam int BIT_SYNC_LOST = 4;
    localparam int BIT_LOWER_PAIR = 5;
    localparam int BIT_UPPER_PAIR = 6;
    localparam int STICKY_W = 5;

    // Field positions inside one pair register, per regulator slot.
    localparam int PAIR_SLOT_W = 4;
    localparam int PAIR_ILIM = 0;
    localparam int PAIR_SHORT = 1;
    localparam int PAIR_GOOD = 2;
    localparam int REG_COUNT = 4;

    // Field positions of the live status and config registers.
    localparam int LIVE_OVERVOLTAGE = 0;
    localparam int LIVE_THERMAL_SD = 1;
    localparam int LIVE_THERMAL_WARN = 2;
    localparam int CFG_WARN_LEVEL = 0;

    // Reset values.
    localparam logic [7:0] MASK_RESET = 8'h7f;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Short-circuit start-up window, as a time and as clock cycles.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SC_START_TIME_US = 1000;
    localparam int SC_START_CYCLES = SC_START_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int SC_CNT_W = 17;

    // One register request of the plain register port.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // States of the per-regulator short-circuit watcher.
    typedef enum logic [3:0] {
        SC_IDLE = 4'b0001,
        SC_RAMP = 4'b0010,
        SC_RUN = 4'b0100,
        SC_FAULT = 4'b1000
    } sc_state_t;

endpackage : irq_status_pkg

`default_nettype wire

// [core/short_detect.sv]
/*
 * Short-circuit watcher for one regulator: flags an output that never
 * reaches the short level within the start window after enable, or that
 * falls below it once running.
 * Assumes the below-level comparator output is synchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none

module short_detect #(
    parameter int LIMIT = irq_status_pkg::SC_START_CYCLES
) (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Regulator state.
    input wire logic enable,
    input wire logic below_level,
    // One-cycle short event.
    output logic sc_event_q
);

    // Watcher state, start window counter and event flop.
    irq_status_pkg::sc_state_t state_q, state_d;
    logic [irq_status_pkg::SC_CNT_W-1:0] count_q, count_d;
    logic sc_event_d;

    // Walk through ramp and run while enabled; a fault waits for disable.
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        sc_event_d = 1'b0;
        if (ce) begin
            case (state_q)
                irq_status_pkg::SC_IDLE: begin
                    count_d = '0;
                    if (enable) begin
                        state_d = irq_status_pkg::SC_RAMP;
                    end
                end
                irq_status_pkg::SC_RAMP: begin
                    count_d = count_q + 1'b1;
                    if (!enable) begin
                        state_d = irq_status_pkg::SC_IDLE;
                    end else if (!below_level) begin
                        state_d = irq_status_pkg::SC_RUN;
                    end else if (count_q ==
                        irq_status_pkg::SC_CNT_W'(LIMIT - 1)) begin
                        state_d = irq_status_pkg::SC_FAULT;
                        sc_event_d = 1'b1;
                    end
                end
                irq_status_pkg::SC_RUN: begin
                    if (!enable) begin
                        state_d = irq_status_pkg::SC_IDLE;
                    end else if (below_level) begin
                        state_d = irq_status_pkg::SC_FAULT;
                        sc_event_d = 1'b1;
                    end
                end
                irq_status_pkg::SC_FAULT: begin
                    if (!enable) begin
                        state_d = irq_status_pkg::SC_IDLE;
                    end
                end
                default: begin
                    state_d = irq_status_pkg::SC_IDLE;
                end
            endcase
        end else begin
            sc_event_d = sc_event_q;
        end
    end

    // Registers of the watcher.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= irq_status_pkg::SC_IDLE;
            count_q <= '0;
            sc_event_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            sc_event_q <= sc_event_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    run_short_a: assert property (
        ce && state_q == irq_status_pkg::SC_RUN && enable && below_level
        |=> sc_event_q && state_q == irq_status_pkg::SC_FAULT)
        else $error("A short while running was not flagged.");

    short_cover_c: cover property (sc_event_q);

endmodule : short_detect

`default_nettype wire

// [core/sticky_flags.sv]
/*
 * A vector of sticky event flags: an event sets its bit, a one written
 * to the clear vector clears it, and a set in the same cycle wins.
 * Assumes set and clear vectors are synchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none

module sticky_flags #(
    parameter int W = 8
) (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Event and clear vectors.
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    // Held flags.
    output logic [W-1:0] flags_q
);

    // Next value of the held flags.
    logic [W-1:0] flags_d;

    // Clears drop only the written ones; the set term goes last so it wins.
    always_comb begin
        flags_d = flags_q;
        if (ce) begin
            flags_d = (flags_q & ~clr_i) | set_i;
        end
    end

    // The flags clear at reset and otherwise register their next value.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    keep_on_zero_a: assert property (
        ce && clr_i == '0 |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("A flag dropped without a written one.");

    clear_on_one_a: assert property (
        ce |=> (flags_q & $past(clr_i) & ~$past(set_i)) == '0)
        else $error("A written one did not clear its flag.");

    set_wins_a: assert property (
        ce |=> (flags_q & $past(set_i)) == $past(set_i))
        else $error("An event was lost against a clear.");

endmodule : sticky_flags

`default_nettype wire

// [core/top_level_interrupt_status.sv]
/*
 * Top-level interrupt status of a multiphase buck controller: two pair
 * summary flags, five sticky events, the two pair event registers, the
 * mask, live status, config and load result registers, the interrupt
 * output and the thermal enable gate.
 * Assumes all inputs are synchronous to clk and one register access at a
 * time on the plain register port.
 */
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module top_level_interrupt_status #(
    parameter int SC_START_CYCLES = irq_status_pkg::SC_START_CYCLES
) (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Register port.
    input wire irq_status_pkg::reg_req_t reg_req,
    output logic [7:0] rdata,
    // Interrupt request.
    output logic irq,
    // Device event inputs.
    input wire logic sync_clock_invalid,
    input wire logic die_over_shutdown,
    input wire logic die_over_warn_low,
    input wire logic die_over_warn_high,
    input wire logic input_overvoltage,
    input wire logic load_result_valid,
    input wire logic [15:0] load_result,
    // Regulator status and control.
    input wire logic [3:0] reg_enable_request,
    input wire logic [3:0] reg_below_sc_level,
    input wire logic [3:0] reg_current_limit,
    input wire logic [3:0] reg_power_good,
    output logic [3:0] reg_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Decode and event terms.

    // Write strobes of each writable register.
    logic wr_top;
    logic wr_lower;
    logic wr_upper;
    logic wr_mask;
    logic wr_config;

    // Sticky top events and their clears.
    logic [4:0] top_set;
    logic [4:0] top_clr;
    logic [4:0] top_q;

    // Both pair registers, lower pair in the low byte.
    logic [15:0] pair_set;
    logic [15:0] pair_clr;
    logic [15:0] pair_q;

    // Per-regulator short events.
    logic [3:0] sc_event;

    // Summary flags and the full status byte.
    logic upper_pair_pending;
    logic lower_pair_pending;
    logic [7:0] top_interrupt_status;

    // Software registers and sampled inputs.
    logic [7:0] mask_q, mask_d;
    logic [7:0] config_q, config_d;
    logic [15:0] load_q, load_d;
    logic [3:0] good_prev_q, good_prev_d;
    logic warn_prev_q, warn_prev_d;
    logic [7:0] rdata_d;
    logic [3:0] reg_enable_d;

    // Live conditions and the selected warning level.
    logic warn_level_hit;
    logic thermal_shutdown_flag;
    logic [7:0] live_status;

    // Write decode: a write goes to one register at its own address.
    assign wr_top = reg_req.wr
        && reg_req.addr == irq_status_pkg::TOP_STATUS_ADDR;
    assign wr_lower = reg_req.wr
        && reg_req.addr == irq_status_pkg::LOWER_PAIR_ADDR;
    assign wr_upper = reg_req.wr
        && reg_req.addr == irq_status_pkg::UPPER_PAIR_ADDR;
    assign wr_mask = reg_req.wr
        && reg_req.addr == irq_status_pkg::TOP_MASK_ADDR;
    assign wr_config = reg_req.wr
        && reg_req.addr == irq_status_pkg::CONFIG_ADDR;

    // The warning comparator follows the selected temperature level.
    assign warn_level_hit = config_q[irq_status_pkg::CFG_WARN_LEVEL]
        ? die_over_warn_high : die_over_warn_low;

    // Top events; the warning latches only on a rising crossing.
    assign top_set[irq_status_pkg::BIT_LOAD_READY] = load_result_valid;
    assign top_set[irq_status_pkg::BIT_OVERVOLTAGE] =
        input_overvoltage;
    assign top_set[irq_status_pkg::BIT_THERMAL_WARN] =
        warn_level_hit && !warn_prev_q;
    assign top_set[irq_status_pkg::BIT_THERMAL_SD] = die_over_shutdown;
    assign top_set[irq_status_pkg::BIT_SYNC_LOST] = sync_clock_invalid;

    // Writing ones to the top register clears those sticky bits.
    assign top_clr = wr_top ? reg_req.wdata[4:0] : 5'h0;

    // Pair clears: each pair register takes its own written ones.
    assign pair_clr = {wr_upper ? reg_req.wdata : irq_status_pkg::ZERO_BYTE,
        wr_lower ? reg_req.wdata : irq_status_pkg::ZERO_BYTE};

    ////////////////////////////////////////////////////////////////////////
    // Per-regulator events and the two pair registers.

    genvar r;
    generate
        for (r = 0; r < irq_status_pkg::REG_COUNT; r = r + 1) begin : g_reg
            // Short watcher on the granted enable of this regulator.
            short_detect #(
                .LIMIT(SC_START_CYCLES)
            ) u_short (
                .clk(clk),
                .reset_n(reset_n),
                .ce(ce),
                .enable(reg_enable[r]),
                .below_level(reg_below_sc_level[r]),
                .sc_event_q(sc_event[r])
            );
            // Slot of this regulator: limit, short, power-good, reserved.
            assign pair_set[r*4+irq_status_pkg::PAIR_ILIM] =
                reg_current_limit[r];
            assign pair_set[r*4+irq_status_pkg::PAIR_SHORT] =
                sc_event[r];
            assign pair_set[r*4+irq_status_pkg::PAIR_GOOD] =
                reg_power_good[r] && !good_prev_q[r];
            assign pair_set[r*4+3] = 1'b0;
        end
        for (r = 0; r < 2; r = r + 1) begin : g_pair
            // Sticky event register of one regulator pair.
            sticky_flags #(
                .W(8)
            ) u_pair (
                .clk(clk),
                .reset_n(reset_n),
                .ce(ce),
                .set_i(pair_set[r*8 +: 8]),
                .clr_i(pair_clr[r*8 +: 8]),
                .flags_q(pair_q[r*8 +: 8])
            );
        end
    endgenerate

    // Sticky part of the top status register.
    sticky_flags #(
        .W(irq_status_pkg::STICKY_W)
    ) u_top (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .set_i(top_set),
        .clr_i(top_clr),
        .flags_q(top_q)
    );

    // Summaries are read-only and fall once their pair is fully cleared.
    assign upper_pair_pending = |pair_q[15:8];
    assign lower_pair_pending = |pair_q[7:0];
    assign top_interrupt_status = {1'b0, upper_pair_pending,
        lower_pair_pending, top_q};
    assign thermal_shutdown_flag = top_q[irq_status_pkg::BIT_THERMAL_SD];

    // Live conditions, independent of the sticky flags.
    assign live_status = {5'h0, warn_level_hit, die_over_shutdown,
        input_overvoltage};

    // Level interrupt while any unmasked status bit is set.
    assign irq = |(top_interrupt_status & ~mask_q);

    ////////////////////////////////////////////////////////////////////////
    // Software registers, read port and enable gate.

    // Next values of all software-visible and sampled registers.
    always_comb begin
        mask_d = mask_q;
        config_d = config_q;
        load_d = load_q;
        good_prev_d = good_prev_q;
        warn_prev_d = warn_prev_q;
        rdata_d = rdata;
        reg_enable_d = reg_enable;
        if (ce) begin
            // Mask and config take whole written bytes.
            if (wr_mask) begin
                mask_d = reg_req.wdata;
            end
            if (wr_config) begin
                config_d = reg_req.wdata;
            end
            // A new result lands together with its ready flag.
            if (load_result_valid) begin
                load_d = load_result;
            end
            good_prev_d = reg_power_good;
            warn_prev_d = warn_level_hit;
            // Shutdown drops running enables and refuses new ones.
            reg_enable_d = reg_enable_request &
                ~{4{thermal_shutdown_flag || die_over_shutdown}};
            // Read data stands only in the cycle after the read strobe.
            rdata_d = irq_status_pkg::ZERO_BYTE;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    irq_status_pkg::TOP_STATUS_ADDR:
                        rdata_d = top_interrupt_status;
                    irq_status_pkg::LOWER_PAIR_ADDR: rdata_d = pair_q[7:0];
                    irq_status_pkg::UPPER_PAIR_ADDR: rdata_d = pair_q[15:8];
                    irq_status_pkg::TOP_MASK_ADDR: rdata_d = mask_q;
                    irq_status_pkg::LIVE_STATUS_ADDR: rdata_d = live_status;
                    irq_status_pkg::CONFIG_ADDR: rdata_d = config_q;
                    irq_status_pkg::LOAD_LO_ADDR: rdata_d = load_q[7:0];
                    irq_status_pkg::LOAD_HI_ADDR: rdata_d = load_q[15:8];
                    default: rdata_d = irq_status_pkg::ZERO_BYTE;
                endcase
            end
        end
    end

    // Registers of the software side; all frozen while ce is low.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_q <= irq_status_pkg::MASK_RESET;
            config_q <= irq_status_pkg::CONFIG_RESET;
            load_q <= 16'h0000;
            good_prev_q <= 4'h0;
            warn_prev_q <= 1'b0;
            rdata <= irq_status_pkg::ZERO_BYTE;
            reg_enable <= 4'h0;
        end else begin
            mask_q <= mask_d;
            config_q <= config_d;
            load_q <= load_d;
            good_prev_q <= good_prev_d;
            warn_prev_q <= warn_prev_d;
            rdata <= rdata_d;
            reg_enable <= reg_enable_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    upper_summary_a: assert property (
        ce && reg_req.rd && reg_req.addr == irq_status_pkg::TOP_STATUS_ADDR
        |=> rdata[irq_status_pkg::BIT_UPPER_PAIR] == $past(|pair_q[15:8]))
        else $error("Upper summary read does not match its pair.");

    lower_drop_a: assert property (
        ce && wr_lower && (pair_q[7:0] & ~reg_req.wdata) == 8'h00
        && pair_set[7:0] == 8'h00 |=> !lower_pair_pending)
        else $error("Lower summary stayed after full clear.");

    shutdown_gate_a: assert property (
        ce && thermal_shutdown_flag |=> reg_enable == 4'h0)
        else $error("A regulator ran during thermal shutdown.");

    overvoltage_latch_a: assert property (
        ce && input_overvoltage |=>
        top_q[irq_status_pkg::BIT_OVERVOLTAGE] ##1
        top_q[irq_status_pkg::BIT_OVERVOLTAGE] || $past(top_clr[1]))
        else $error("Overvoltage flag did not latch.");

    load_ready_a: assert property (
        ce && load_result_valid |=> load_q == $past(load_result)
        && top_q[irq_status_pkg::BIT_LOAD_READY])
        else $error("Load result and ready flag disagree.");

    sync_lost_a: assert property (
        ce && sync_clock_invalid |=> top_q[irq_status_pkg::BIT_SYNC_LOST])
        else $error("Sync loss was not latched.");

    irq_level_a: assert property (
        ce && sync_clock_invalid && !mask_q[irq_status_pkg::BIT_SYNC_LOST]
        && !wr_mask |=> irq)
        else $error("Unmasked sync loss gave no interrupt.");

    shutdown_cover_c: cover property (
        thermal_shutdown_flag ##1 !thermal_shutdown_flag);
    irq_cover_c: cover property (!irq ##1 irq);
    read_cover_c: cover property (
        reg_req.rd ##1 rdata != irq_status_pkg::ZERO_BYTE);

endmodule : top_level_interrupt_status

`default_nettype wire

// [sim/top_level_interrupt_status_test.sv]
/*
 * Self-checking bench of the top-level interrupt status block: register
 * reads and writes over the plain port, event pulses and compares.
 * Assumes the package and design files under core/ are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module top_level_interrupt_status_test;

    ////////////////////////////////////////////////////////////////////
    // Drive and observe signals; the clock enable drops in one scenario.
    logic clk, reset_n, ce, irq;
    irq_status_pkg::reg_req_t req;
    logic [7:0] rdata;
    logic sync_lost, shut, warn_lo, warn_hi, ovp, ld_vld;
    logic [15:0] ld_res;
    logic [3:0] en_req, below, ilim, pgood, en_out;
    int err_count, checks;

    // Short start window shortened to keep the run brief.
    top_level_interrupt_status #(.SC_START_CYCLES(20)) dut_u (
        .clk(clk), .reset_n(reset_n), .ce(ce), .reg_req(req),
        .rdata(rdata), .irq(irq), .sync_clock_invalid(sync_lost),
        .die_over_shutdown(shut), .die_over_warn_low(warn_lo),
        .die_over_warn_high(warn_hi), .input_overvoltage(ovp),
        .load_result_valid(ld_vld), .load_result(ld_res),
        .reg_enable_request(en_req), .reg_below_sc_level(below),
        .reg_current_limit(ilim), .reg_power_good(pgood),
        .reg_enable(en_out));

    ////////////////////////////////////////////////////////////////////
    // The clock toggles every 5 ns for a 100 MHz rate.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Waits a number of rising edges.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One-cycle write strobe beside address and data.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    // One-cycle read strobe; data stand only in the following cycle.
    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [7:0] e);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask : rchk

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////
    // Cuts a hang short well beyond the expected run time.
    initial begin
        #100000;
        err_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence: reset, then one scenario per behaviour.
    initial begin
        {sync_lost, shut, warn_lo, warn_hi, ovp, ld_vld} = 6'h00;
        {en_req, below, ilim, pgood} = 16'h0000;
        ld_res = 16'h0000;
        req = '0;
        ce = 1'b1;
        reset_n = 1'b0;
        err_count = 0;
        checks = 0;
        tick(3);
        reset_n <= 1'b1;
        // Reset values and an unmapped address.
        rchk("status", 8'h1a, 8'h00);
        rchk("mask", 8'h20, 8'h7f);
        rchk("unmapped", 8'h30, 8'h00);
        chk("irq", 8'h00, {7'h00, irq});
        // Sync loss latches; a zero write keeps it, and unmasked it raises irq.
        sync_lost <= 1'b1;
        tick(2);
        sync_lost <= 1'b0;
        tick(2);
        rchk("status", 8'h1a, 8'h10);
        wr(8'h1a, 8'h00);
        rchk("status", 8'h1a, 8'h10);
        wr(8'h20, 8'h6f);
        #1 chk("irq", 8'h01, {7'h00, irq});
        // A clear beside a fresh sync loss keeps the flag: set wins.
        sync_lost <= 1'b1;
        wr(8'h1a, 8'h10);
        sync_lost <= 1'b0;
        rchk("status", 8'h1a, 8'h10);
        wr(8'h1a, 8'h10);
        rchk("status", 8'h1a, 8'h00);
        chk("irq", 8'h00, {7'h00, irq});
        // Overvoltage: live bit follows, sticky bit stays.
        ovp <= 1'b1;
        tick(2);
        rchk("live", 8'h21, 8'h01);
        ovp <= 1'b0;
        tick(2);
        rchk("live", 8'h21, 8'h00);
        rchk("status", 8'h1a, 8'h02);
        wr(8'h1a, 8'h02);
        // Load result stored in both bytes with its ready flag.
        ld_res <= 16'h5a3c;
        ld_vld <= 1'b1;
        tick(1);
        ld_vld <= 1'b0;
        tick(1);
        rchk("load_lo", 8'h23, 8'h3c);
        rchk("load_hi", 8'h24, 8'h5a);
        rchk("status", 8'h1a, 8'h01);
        wr(8'h1a, 8'h01);
        // Warning: only the selected (low) comparator counts.
        warn_hi <= 1'b1;
        tick(2);
        rchk("status", 8'h1a, 8'h00);
        warn_lo <= 1'b1;
        tick(2);
        rchk("live", 8'h21, 8'h04);
        {warn_lo, warn_hi} <= 2'b00;
        rchk("status", 8'h1a, 8'h04);
        wr(8'h1a, 8'h04);
        rchk("status", 8'h1a, 8'h00);
        // High level selected: now only the high comparator counts.
        wr(8'h22, 8'h01);
        rchk("config", 8'h22, 8'h01);
        warn_lo <= 1'b1;
        tick(2);
        rchk("status", 8'h1a, 8'h00);
        warn_hi <= 1'b1;
        tick(2);
        {warn_lo, warn_hi} <= 2'b00;
        rchk("status", 8'h1a, 8'h04);
        wr(8'h1a, 8'h04);
        // Thermal shutdown stops enables until software clears it.
        en_req <= 4'hf;
        tick(2);
        chk("enable", 8'h0f, {4'h0, en_out});
        shut <= 1'b1;
        tick(2);
        rchk("live", 8'h21, 8'h02);
        shut <= 1'b0;
        tick(2);
        chk("enable", 8'h00, {4'h0, en_out});
        rchk("status", 8'h1a, 8'h08);
        chk("enable", 8'h00, {4'h0, en_out});
        wr(8'h1a, 8'h08);
        tick(2);
        chk("enable", 8'h0f, {4'h0, en_out});
        // Short while running on slot 1 sets the lower pair summary.
        tick(3);
        below <= 4'h2;
        pgood <= 4'h1;
        tick(2);
        below <= 4'h0;
        tick(2);
        rchk("lower", 8'h1c, 8'h24);
        rchk("status", 8'h1a, 8'h20);
        wr(8'h1c, 8'h20);
        rchk("lower", 8'h1c, 8'h04);
        rchk("status", 8'h1a, 8'h20);
        wr(8'h1c, 8'h04);
        rchk("lower", 8'h1c, 8'h00);
        rchk("status", 8'h1a, 8'h00);
        // Current limit on slot 2 sets the upper pair summary.
        ilim <= 4'h4;
        tick(2);
        ilim <= 4'h0;
        tick(2);
        rchk("upper", 8'h1d, 8'h01);
        rchk("status", 8'h1a, 8'h40);
        wr(8'h1a, 8'he0);
        rchk("status", 8'h1a, 8'h40);
        wr(8'h1d, 8'h01);
        rchk("status", 8'h1a, 8'h00);
        // Slot 3 never reaches the level within the start window.
        en_req <= 4'h0;
        tick(2);
        below <= 4'h8;
        en_req <= 4'h8;
        tick(21);
        rchk("upper", 8'h1d, 8'h00);
        rchk("upper", 8'h1d, 8'h20);
        below <= 4'h0;
        en_req <= 4'h0;
        tick(2);
        wr(8'h1d, 8'h20);
        rchk("status", 8'h1a, 8'h00);
        // With the clock enable low a write strobe is ignored.
        ce <= 1'b0;
        wr(8'h20, 8'h00);
        ce <= 1'b1;
        rchk("mask", 8'h20, 8'h6f);
        close_out();
    end

endmodule : top_level_interrupt_status_test

`default_nettype wire
